//--- verilog/meter_host_pkg.sv
// Shared constants and carriers for the meter host status unit.
// Assumes a 200 MHz core clock and a separate serial-link clock domain.
package meter_host_pkg;
   // Core clock rate
   localparam int unsigned CORE_CLK_HZ      = 200_000_000;
   // Supervision timing
   localparam int unsigned SUP_PULSE_US     = 16_000;      // 16 ms
   localparam int unsigned SUP_PERIOD_MS    = 1_600;       // 1.6 s
   // Cycle counts derived from the rate (pulse min rounds up, period max rounds down)
   localparam longint unsigned SUP_PULSE_CYC  =
      (longint'(SUP_PULSE_US) * CORE_CLK_HZ + 999_999) / 1_000_000;
   localparam longint unsigned SUP_PERIOD_CYC =
      (longint'(SUP_PERIOD_MS) * CORE_CLK_HZ) / 1_000;
   // Counter width for supervision timer
   localparam int unsigned SUP_CNT_W        = 32;
   // Energy pulse tap position
   localparam int unsigned WIDEBAND_TAP_BIT = 11;
   localparam int unsigned ACC_W            = 20;
   // Pulse source select codes
   localparam logic [1:0]  SRC_WIDEBAND     = 2'h0;
   localparam logic [1:0]  SRC_FUNDAMENTAL  = 2'h1;
   localparam logic [1:0]  SRC_REACTIVE     = 2'h2;
   localparam logic [1:0]  SRC_APPARENT     = 2'h3;
   // Status word bit positions
   localparam int unsigned ST_NO_LOAD       = 0;
   localparam int unsigned ST_MOD_STUCK     = 1;
   localparam int unsigned ST_FREQ_RANGE    = 2;
   localparam int unsigned ST_TAMPER        = 3;
   localparam int unsigned ST_CHANNEL       = 4;
   localparam int unsigned ST_TREND         = 5;
   localparam int unsigned ST_PIN_CHECK     = 6;
   localparam int unsigned ST_INVALID       = 7;
   // Record layout
   localparam int unsigned NUM_RECORDS      = 8;
   localparam int unsigned NUM_RO_RECORDS   = 6;
   localparam int unsigned REC_DATA_W       = 28;
   localparam int unsigned REC_PAR_W        = 4;
   localparam int unsigned REC_NIBBLES      = 7;
   localparam int unsigned MODE_RECORD_IDX  = 1;
   localparam int unsigned MODE_LSB         = 0;
   localparam int unsigned MODE_W           = 8;
   localparam int unsigned CFG_LOW_IDX      = 6;
   localparam int unsigned CFG_HIGH_IDX     = 7;
   // Configuration bit positions inside the low config record
   localparam int unsigned CFG_CLK_RANGE    = 1;
   localparam int unsigned CFG_FREEZE_SEL   = 8;
   localparam int unsigned CFG_ORDER_SEL    = 9;
   localparam int unsigned CFG_SRC_LSB      = 14;
   // Reset values
   localparam logic [REC_DATA_W-1:0] REC_RESET = 28'h0000000;
   // Restart hold after reset before records become valid
   localparam int unsigned RESTART_CYC      = 64;

   // Write request from the serial link
   typedef struct packed {
      logic [2:0]            idx;
      logic [REC_DATA_W-1:0] data;
   } rec_write_type;

   // Measurement status inputs
   typedef struct packed {
      logic no_load;
      logic mod_stuck;
      logic freq_range;
      logic tamper;
      logic channel;
      logic trend;
   } meas_status_type;
endpackage : meter_host_pkg

//--- verilog/meter_host_status_unit.sv
// Host-facing supervision, energy pulse, status word and data records.
// Assumes DSP results arrive on the core clock and writes on the link clock.
//
// How it works
// [RULE1] Supervision pin pulses 16 ms every 1.6 s
// [RULE2] Each latch request restarts supervision timer
// [RULE3] Low analog supply holds supervision output high
// [RULE4] Host should read at least once per second
// [RULE5] Energy pulse output has 50% duty cycle
// [RULE6] Wide-band pulse taken from accumulator bit 11
// [RULE7] Two-bit select routes four energy sources
// [RULE8] Status bit 0 reports no-load
// [RULE9] Status bit 1 reports stuck modulator
// [RULE10] Status bit 2 flags frequency outside 45-65 Hz
// [RULE11] Status bit 3 reports tamper
// [RULE12] Status bit 4 reports selected current channel
// [RULE13] Status bit 5 reports voltage falling trend
// [RULE14] Status bit 6 flags forced output pin
// [RULE15] Status bit 7 marks records invalid after reset
// [RULE16] Eight records, parity nibble plus 28 data
// [RULE17] Parity bit is odd parity across nibbles
// [RULE18] Six read-only records, mode byte, two config
// [RULE19] Freeze select zeroes power when frequency out
// [RULE20] Order select picks MSB or LSB first
// [RULE21] Parity recomputed combinationally on every read
// [RULE22] Supervision counts scaled by clock range
`timescale 1ns/1ps
`default_nettype none
module meter_host_status_unit
   import meter_host_pkg::*;
#(
   parameter longint unsigned PULSE_CYC  = meter_host_pkg::SUP_PULSE_CYC,
   parameter longint unsigned PERIOD_CYC = meter_host_pkg::SUP_PERIOD_CYC
)(
   input  wire logic                              i_core_clk,     // Core clock
   input  wire logic                              i_rst,          // Sync reset, high
   input  wire logic                              i_link_clk,     // Serial link clock
   input  wire logic                              i_link_rst,     // Link-domain reset
   input  wire logic                              i_latch_request_pin, // Async pin
   input  wire logic                              i_analog_supply_ok,  // Async, high above 2.5 V
   input  wire logic [meter_host_pkg::ACC_W-1:0]  i_active_acc,   // Wide-band accumulator
   input  wire logic                              i_fundamental_active_pulse,
   input  wire logic                              i_reactive_pulse,
   input  wire logic                              i_apparent_pulse,
   input  wire meter_host_pkg::meas_status_type   i_meas_status,  // DSP flags
   input  wire logic                              i_pin_observed, // Async pin readback
   input  wire logic                              i_restart_done, // DSP restarted
   input  wire logic [meter_host_pkg::REC_DATA_W*6-1:0] i_ro_data, // Six DSP records
   input  wire logic                              i_link_wr_valid, // Link write strobe
   input  wire meter_host_pkg::rec_write_type     i_link_wr,       // Link write word
   input  wire logic [2:0]                        i_rd_idx,        // Record read index
   output logic                                   o_supervision_pin,
   output logic                                   o_energy_pulse,
   output logic [7:0]                             o_status,
   output logic [31:0]                            o_rd_record,
   output logic                                   o_freeze_accum,
   output logic                                   o_lsb_first,
   output logic [7:0]                             o_mode_signals
);
   import meter_host_pkg::*;

   // Odd parity nibble over seven data nibbles
   function automatic logic [REC_PAR_W-1:0] odd_par(input logic [REC_DATA_W-1:0] d);
      logic [REC_PAR_W-1:0] p;
      p = '1;
      for (int n = 0; n < REC_NIBBLES; n++)
      begin
         p = p ^ d[n*4 +: 4];                                  // [RULE17]
      end
      return p;
   endfunction : odd_par

   // Synchroniser stages for pins
   logic [1:0] latch_sync_q;      // Latch pin sync
   logic [1:0] supply_sync_q;     // Supply-ok sync
   logic [1:0] pinobs_sync_q;     // Pin readback sync
   logic       latch_prev_q;      // Edge detector state
   logic [1:0] sup_dly_q;         // Pin drive, aligned with readback sync

   // Two-flop synchronisers
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         latch_sync_q  <= 2'h0;
         supply_sync_q <= 2'h0;
         pinobs_sync_q <= 2'h0;
         latch_prev_q  <= 1'b0;
         sup_dly_q     <= 2'h0;
      end
      else
      begin
         latch_sync_q  <= {latch_sync_q[0], i_latch_request_pin};
         supply_sync_q <= {supply_sync_q[0], i_analog_supply_ok};
         pinobs_sync_q <= {pinobs_sync_q[0], i_pin_observed};
         latch_prev_q  <= latch_sync_q[1];
         sup_dly_q     <= {sup_dly_q[0], o_supervision_pin}; // Same lag as readback
      end
   end

   logic latch_event;             // Rising edge of latch request
   assign latch_event = latch_sync_q[1] & ~latch_prev_q;

   // Link-domain write capture with toggle handshake
   rec_write_type link_wr_q;      // Held write word
   logic          link_tog_q;     // Event toggle
   logic [1:0]    ack_sync_q;     // Ack toggle back into link
   logic          busy_q;         // Word held, not acknowledged
   logic [2:0]    req_sync_q;     // Request toggle into core
   logic          core_ack_q;     // Ack toggle toward link

   // Capture writes when the previous one has been taken
   always_ff @(posedge i_link_clk)
   begin
      if (i_link_rst)
      begin
         link_wr_q  <= '0;
         link_tog_q <= 1'b0;
         busy_q     <= 1'b0;
         ack_sync_q <= 2'h0;
      end
      else
      begin
         ack_sync_q <= {ack_sync_q[0], core_ack_q};
         if (busy_q && (ack_sync_q[1] == link_tog_q))
         begin
            busy_q <= 1'b0;                                   // Acknowledged
         end
         else if (!busy_q && i_link_wr_valid)
         begin
            link_wr_q  <= i_link_wr;                          // Hold stable word
            link_tog_q <= ~link_tog_q;
            busy_q     <= 1'b1;
         end
      end
   end

   // Request toggle synchroniser in core domain
   // Runs through reset, so a toggle seen before reset is not applied again
   always_ff @(posedge i_core_clk)
   begin
      req_sync_q <= {req_sync_q[1:0], link_tog_q};
      core_ack_q <= req_sync_q[2];
   end

   logic wr_event;                // Write word stable and new
   assign wr_event = req_sync_q[2] ^ core_ack_q;

   // Writable storage: mode byte and two config records
   logic [MODE_W-1:0]     mode_q;      // Mode signals
   logic [REC_DATA_W-1:0] cfg_low_q;   // Config record low
   logic [REC_DATA_W-1:0] cfg_high_q;  // Config record high

   // Writes accepted only where writable
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         mode_q     <= '0;
         cfg_low_q  <= REC_RESET;
         cfg_high_q <= REC_RESET;
      end
      else if (wr_event)
      begin
         case (link_wr_q.idx)                                  // [RULE18]
            3'(MODE_RECORD_IDX): mode_q     <= link_wr_q.data[MODE_LSB +: MODE_W];
            3'(CFG_LOW_IDX):     cfg_low_q  <= link_wr_q.data;
            3'(CFG_HIGH_IDX):    cfg_high_q <= link_wr_q.data;
            default:             mode_q     <= mode_q;        // Read-only, ignored
         endcase
      end
   end

   // Supervision timer, scaled by clock range
   logic [SUP_CNT_W-1:0] sup_cnt_q;   // Cycles since last restart
   logic [SUP_CNT_W-1:0] period_lim;  // Scaled interval
   logic [SUP_CNT_W-1:0] pulse_lim;   // Scaled width
   logic                 sup_pulse_q; // Pulse active

   // Half-rate range divides the counts by two
   assign period_lim = cfg_low_q[CFG_CLK_RANGE] ? SUP_CNT_W'(PERIOD_CYC)
                                                : SUP_CNT_W'(PERIOD_CYC >> 1); // [RULE22]
   assign pulse_lim  = cfg_low_q[CFG_CLK_RANGE] ? SUP_CNT_W'(PULSE_CYC)
                                                : SUP_CNT_W'(PULSE_CYC >> 1);  // [RULE22]

   // Interval and pulse counting
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst || !supply_sync_q[1])
      begin
         sup_cnt_q   <= '0;
         sup_pulse_q <= 1'b0;
      end
      else if (latch_event)
      begin
         sup_cnt_q   <= '0;                                    // [RULE2]
         sup_pulse_q <= 1'b0;
      end
      else if (sup_pulse_q)
      begin
         if (sup_cnt_q >= pulse_lim - 1'b1)
         begin
            sup_cnt_q   <= '0;                                 // [RULE1]
            sup_pulse_q <= 1'b0;
         end
         else
         begin
            sup_cnt_q <= sup_cnt_q + 1'b1;
         end
      end
      else if (sup_cnt_q >= period_lim - pulse_lim - 1'b1)
      begin
         sup_cnt_q   <= '0;                                    // [RULE1]
         sup_pulse_q <= 1'b1;
      end
      else
      begin
         sup_cnt_q <= sup_cnt_q + 1'b1;
      end
   end

   // Output register; low supply forces high
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
         o_supervision_pin <= 1'b1;
      else
         o_supervision_pin <= !supply_sync_q[1] | sup_pulse_q; // [RULE3]
   end

   // Energy pulse selection
   logic [1:0] src_sel;            // Pulse source select
   logic       pulse_mux;          // Selected source
   assign src_sel = cfg_low_q[CFG_SRC_LSB +: 2];

   // Tap bit toggles with 50% duty
   always_comb
   begin
      case (src_sel)                                           // [RULE7]
         SRC_WIDEBAND:    pulse_mux = i_active_acc[WIDEBAND_TAP_BIT]; // [RULE6] [RULE5]
         SRC_FUNDAMENTAL: pulse_mux = i_fundamental_active_pulse;
         SRC_REACTIVE:    pulse_mux = i_reactive_pulse;
         SRC_APPARENT:    pulse_mux = i_apparent_pulse;
         default:         pulse_mux = 1'b0;
      endcase
   end

   // Registered pulse output
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
         o_energy_pulse <= 1'b0;
      else
         o_energy_pulse <= pulse_mux;                          // [RULE5]
   end

   // Restart validity tracking
   logic [6:0] restart_cnt_q;      // Cycles since reset
   logic       invalid_q;          // Records invalid

   // Invalid from reset until restart done and settle time
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         restart_cnt_q <= '0;
         invalid_q     <= 1'b1;                                // [RULE15]
      end
      else if (restart_cnt_q < 7'(RESTART_CYC))
      begin
         restart_cnt_q <= restart_cnt_q + 1'b1;
      end
      else if (i_restart_done)
      begin
         invalid_q <= 1'b0;                                    // [RULE15]
      end
   end

   // Status word register
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         o_status <= 8'h80;
      end
      else
      begin
         o_status[ST_NO_LOAD]    <= i_meas_status.no_load;     // [RULE8]
         o_status[ST_MOD_STUCK]  <= i_meas_status.mod_stuck;   // [RULE9]
         o_status[ST_FREQ_RANGE] <= i_meas_status.freq_range;  // [RULE10]
         o_status[ST_TAMPER]     <= i_meas_status.tamper;      // [RULE11]
         o_status[ST_CHANNEL]    <= i_meas_status.channel;     // [RULE12]
         o_status[ST_TREND]      <= i_meas_status.trend;       // [RULE13]
         o_status[ST_PIN_CHECK]  <= pinobs_sync_q[1] ^ sup_dly_q[1]; // [RULE14]
         o_status[ST_INVALID]    <= invalid_q;                 // [RULE15]
      end
   end

   // Record data selection
   logic [REC_DATA_W-1:0] rd_data;  // Selected data value
   always_comb
   begin
      rd_data = REC_RESET;
      if (i_rd_idx == 3'(CFG_LOW_IDX))
         rd_data = cfg_low_q;
      else if (i_rd_idx == 3'(CFG_HIGH_IDX))
         rd_data = cfg_high_q;
      else
      begin
         rd_data = i_ro_data[i_rd_idx*REC_DATA_W +: REC_DATA_W]; // [RULE16]
         if (i_rd_idx == 3'(MODE_RECORD_IDX))
            rd_data[MODE_LSB +: MODE_W] = mode_q;
      end
   end

   // Registered readout with fresh parity
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
         o_rd_record <= 32'h00000000;
      else
         o_rd_record <= {odd_par(rd_data), rd_data};           // [RULE21] [RULE16]
   end

   // Configuration-driven controls
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         o_freeze_accum <= 1'b0;
         o_lsb_first    <= 1'b0;
         o_mode_signals <= 8'h00;
      end
      else
      begin
         o_freeze_accum <= i_meas_status.freq_range & ~cfg_low_q[CFG_FREEZE_SEL]; // [RULE19]
         o_lsb_first    <= cfg_low_q[CFG_ORDER_SEL];           // [RULE20]
         o_mode_signals <= mode_q;
      end
   end
endmodule : meter_host_status_unit
`default_nettype wire

//--- tb/meter_host_status_unit_chk.sv
// Port assertions for the meter host status unit.
// Assumes core-clock sampling and the bench's short supervision counts.
`timescale 1ns/1ps
`default_nettype none
module meter_host_status_unit_chk
   import meter_host_pkg::*;
#(
   parameter longint unsigned PULSE_CYC  = 20,
   parameter longint unsigned PERIOD_CYC = 200
)(
   input wire logic                                i_core_clk,
   input wire logic                                i_rst,
   input wire logic                                i_latch_request_pin,
   input wire logic                                i_analog_supply_ok,
   input wire meter_host_pkg::meas_status_type     i_meas_status,
   input wire logic                                i_pin_observed,
   input wire logic [meter_host_pkg::REC_DATA_W*6-1:0] i_ro_data,
   input wire logic [2:0]                          i_rd_idx,
   input wire logic                                o_supervision_pin,
   input wire logic [7:0]                          o_status,
   input wire logic [31:0]                         o_rd_record,
   input wire logic                                o_freeze_accum
);
   logic [31:0] idle_q;  // Cycles since a timer restart cause
   logic [31:0] high_q;  // Cycles the pin has been high
   logic [27:0] ro_sel;  // Read-only record picked by index
   logic [3:0]  par_exp; // Odd parity of the shown data
   assign ro_sel = i_ro_data[i_rd_idx*28 +: 28];
   assign par_exp = ~(o_rd_record[3:0] ^ o_rd_record[7:4] ^ o_rd_record[11:8]
      ^ o_rd_record[15:12] ^ o_rd_record[19:16] ^ o_rd_record[23:20] ^ o_rd_record[27:24]);
   // Idle counter, cleared by latch pin or low supply
   always_ff @(posedge i_core_clk)
      idle_q <= (i_rst || i_latch_request_pin || !i_analog_supply_ok) ? '0 : idle_q + 1;
   // High-time counter of the supervision pin
   always_ff @(posedge i_core_clk)
      high_q <= o_supervision_pin ? high_q + 1 : '0;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   a_supply_low_high: assert property (!i_analog_supply_ok [*4] |-> o_supervision_pin)
      else $error("supervision pin low while supply low");
   a_latch_restart: assert property ($rose(o_supervision_pin) && i_analog_supply_ok
      |-> idle_q >= PERIOD_CYC / 2 - 8) else $error("supervision pulse too early");
   a_pulse_width: assert property ($fell(o_supervision_pin) && idle_q > PULSE_CYC + 8
      |-> $past(high_q) >= PULSE_CYC / 2 - 2) else $error("supervision pulse too short");
   a_status_map: assert property ($stable(i_meas_status) [*3] ##0 !$past(i_rst)
      |-> o_status[5:0] ==
      {i_meas_status.trend, i_meas_status.channel, i_meas_status.tamper,
       i_meas_status.freq_range, i_meas_status.mod_stuck, i_meas_status.no_load})
      else $error("status bits do not follow flags");
   a_freeze_idle: assert property (!i_meas_status.freq_range [*3] |-> !o_freeze_accum)
      else $error("freeze raised with frequency in range");
   a_pin_match: assert property ((o_supervision_pin == i_pin_observed) [*5] |-> !o_status[6])
      else $error("pin check set while pin agrees");
   a_pin_differ: assert property ((o_supervision_pin != i_pin_observed) [*5] |-> o_status[6])
      else $error("pin check clear while pin forced");
   a_parity_odd: assert property (!$past(i_rst) |-> o_rd_record[31:28] == par_exp)
      else $error("record parity wrong");
   a_ro_read: assert property (!$past(i_rst) && $past(i_rd_idx) != 3'h1 && $past(i_rd_idx) < 3'h6
      |-> o_rd_record[27:0] == $past(ro_sel)) else $error("read-only record wrong");
   a_invalid_hold: assert property ($fell(i_rst) |-> o_status[7] [*8])
      else $error("invalid flag not set after reset");
endmodule : meter_host_status_unit_chk
bind meter_host_status_unit meter_host_status_unit_chk #(
   .PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) i_chk (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_latch_request_pin(i_latch_request_pin),
   .i_analog_supply_ok(i_analog_supply_ok), .i_meas_status(i_meas_status),
   .i_pin_observed(i_pin_observed), .i_ro_data(i_ro_data), .i_rd_idx(i_rd_idx),
   .o_supervision_pin(o_supervision_pin), .o_status(o_status),
   .o_rd_record(o_rd_record), .o_freeze_accum(o_freeze_accum));
`default_nettype wire

//--- tb/meter_host_model.sv
// Host controller model: link clock, link writes and latch requests.
// Assumes the link clock stands low between transfers.
`timescale 1ns/1ps
`default_nettype none
module meter_host_model
   import meter_host_pkg::*;
(
   output logic                           o_link_clk,
   output logic                           o_link_rst,
   output logic                           o_wr_valid,
   output meter_host_pkg::rec_write_type  o_wr,
   output logic                           o_latch_pin
);
   import meter_host_pkg::*;
   // Idle levels
   initial
   begin
      o_link_clk = 1'b0;
      o_link_rst = 1'b1;
      o_wr_valid = 1'b0;
      o_wr = '1;
      o_latch_pin = 1'b0;
   end
   // Run whole link clock cycles, 30 ns each
   task automatic cycles(input int n);
      repeat (n)
      begin
         #15 o_link_clk = 1'b1;
         #15 o_link_clk = 1'b0;
      end
   endtask : cycles
   // Link reset, released just after a rising edge
   task automatic reset;
      cycles(3);
      #15 o_link_clk = 1'b1;
      #1 o_link_rst = 1'b0;
      #14 o_link_clk = 1'b0;
   endtask : reset
   // One write, held to the taking edge, then spaced out
   task automatic write(input rec_write_type w);
      #7 o_wr_valid = 1'b1;
      o_wr = w;
      #15 o_link_clk = 1'b1;
      #1 o_wr_valid = 1'b0;
      o_wr = ~w;
      #14 o_link_clk = 1'b0;
      cycles(12);
   endtask : write
   // Latch request pulse; host services regularly
   task automatic latch;
      o_latch_pin = 1'b1;
      #40 o_latch_pin = 1'b0;
   endtask : latch
endmodule : meter_host_model
`default_nettype wire

//--- tb/meter_host_status_unit_test.sv
// Self-checking bench for the meter host status unit.
// Assumes short supervision counts set by parameter.
`timescale 1ns/1ps
`default_nettype none
module meter_host_status_unit_test;
   import meter_host_pkg::*;
   localparam longint unsigned PULSE = 20;
   localparam longint unsigned PERIOD = 200;
   logic i_core_clk, i_rst, supply_ok, bad, done, fund, react, appar;
   logic sup_pin, epulse, freeze, lsb;
   logic [ACC_W-1:0] acc;
   meas_status_type meas;
   logic [REC_DATA_W*6-1:0] ro;
   logic [2:0] rd_idx;
   logic link_clk, link_rst, wr_valid, latch_pin;
   rec_write_type wr;
   logic [7:0] status, mode;
   logic [31:0] rec;
   logic [11:0] rows [8] = '{12'h801, 12'h402, 12'h204, 12'h108,
                             12'h090, 12'h060, 12'hFFF, 12'h000};
   int failures, compares, cyc, n, hi;
   meter_host_model i_meter_host_model (.o_link_clk(link_clk), .o_link_rst(link_rst),
      .o_wr_valid(wr_valid), .o_wr(wr), .o_latch_pin(latch_pin));
   meter_host_status_unit #(.PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD)) i_meter_host_status_unit (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_link_clk(link_clk), .i_link_rst(link_rst),
      .i_latch_request_pin(latch_pin), .i_analog_supply_ok(supply_ok), .i_active_acc(acc),
      .i_fundamental_active_pulse(fund), .i_reactive_pulse(react), .i_apparent_pulse(appar),
      .i_meas_status(meas), .i_pin_observed(sup_pin ^ bad), .i_restart_done(done),
      .i_ro_data(ro), .i_link_wr_valid(wr_valid), .i_link_wr(wr), .i_rd_idx(rd_idx),
      .o_supervision_pin(sup_pin), .o_energy_pulse(epulse), .o_status(status),
      .o_rd_record(rec), .o_freeze_accum(freeze), .o_lsb_first(lsb), .o_mode_signals(mode));
   // Core clock, 5 ns
   initial
   begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   // Hang guard
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge i_core_clk);
      #1;
   endtask : tick
   // Record with odd parity nibble
   function automatic logic [31:0] rec_of(input logic [27:0] d);
      return {~(d[3:0] ^ d[7:4] ^ d[11:8] ^ d[15:12] ^ d[19:16] ^ d[23:20] ^ d[27:24]), d};
   endfunction : rec_of
   task automatic put(input logic [2:0] i, input logic [27:0] d);
      i_meter_host_model.write('{i, d});
      tick(2);
   endtask : put
   task automatic final_report;
      if (failures == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   // Main sequence
   initial
   begin
      {i_rst, supply_ok, bad, done, fund, react, appar} = 7'h40;
      {acc, meas, rd_idx, failures, compares, cyc} = '0;
      for (int k = 0; k < 6; k++) ro[k*28 +: 28] = 28'h13579BD ^ (k * 28'h0F0F0F1);
      tick(3);
      check({sup_pin, status}, 9'h180);
      i_rst = 1'b0;
      i_meter_host_model.reset();
      tick(10);
      check(sup_pin, 1);
      supply_ok = 1'b1;
      tick(70);
      check(status[7], 1);
      done = 1'b1;
      tick(5);
      check(status[7], 0);
      foreach (rows[r])
      begin
         meas = rows[r][11:6];
         tick(3);
         check(status[5:0], rows[r][5:0]);
         check(freeze, rows[r][9]);
      end
      put(3'h0, ~ro[27:0]);
      put(3'h1, 28'hFFFFFA5);
      check(mode, 8'hA5);
      for (int k = 0; k < 6; k++)
      begin
         rd_idx = 3'(k);
         tick(2);
         check(rec, rec_of(k == 1 ? {ro[36 +: 20], 8'hA5} : ro[k*28 +: 28]));
      end
      put(3'h7, 28'h8C0FFEE);
      rd_idx = 3'h7;
      tick(2);
      check(rec, rec_of(28'h8C0FFEE));
      meas = 6'h08;
      put(3'h6, 28'h0000302);
      rd_idx = 3'h6;
      tick(2);
      check(rec, rec_of(28'h0000302));
      check({lsb, freeze}, 2'b10);
      for (int k = 0; k < 4; k++)
      begin
         put(3'h6, (k << 14) | 2);
         for (int v = 0; v < 2; v++)
         begin
            {appar, react, fund, acc[11]} = v ? ~(4'h1 << k) : 4'h1 << k;
            tick(4);
            check(epulse, !v);
         end
      end
      put(3'h6, 28'h0000002);
      hi = 0;
      for (int i = 0; i < 8200; i++)
      begin
         acc = i[12:0];
         tick(1);
         hi += epulse;
         if (i == 2559) check(hi, 512);
      end
      check(hi, 4096);
      bad = 1'b1;
      tick(8);
      check(status[6], 1);
      bad = 1'b0;
      tick(8);
      check(status[6], 0);
      for (n = 0; sup_pin && n < 100; n++) tick(1);
      for (int p = 0; p < 2; p++)
      begin
         for (n = 0; !sup_pin && n < 600; n++) tick(1);
         if (p) check(n + hi >= PERIOD - 3 && n + hi <= PERIOD + 3, 1);
         for (hi = 0; sup_pin && hi < 100; hi++) tick(1);
         check(hi >= PULSE - 1 && hi <= PULSE + 1, 1);
      end
      for (int i = 0; i < 8; i++)
      begin
         i_meter_host_model.latch();
         tick(150);
         check(sup_pin, 0);
      end
      supply_ok = 1'b0;
      tick(6);
      check(sup_pin, 1);
      i_rst = 1'b1;
      tick(3);
      check(status, 8'h80);
      i_rst = 1'b0;
      tick(4);
      check({status[7], mode, lsb, freeze}, 11'h401);
      final_report();
   end
endmodule : meter_host_status_unit_test
`default_nettype wire
